// file: rtl/iie_gate.sv
// sticky request flags and enable gating toward the arbitration logic
`timescale 1ns/1ps
module iie_gate
    import iie_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         clk_en,
    input  wire iie_irq_vec_t src_req,
    input  wire iie_irq_vec_t enable,
    input  wire iie_irq_vec_t flag_clr,
    output iie_irq_vec_t      flag,
    output iie_irq_vec_t      gated
);

    // ------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------
    logic [31:0] flag_next;
    logic [31:0] gated_next;

    // a request in the clearing cycle survives: set beats clear
    assign flag_next  = (flag & ~flag_clr) | (src_req & VEC_IMPL);
    // flags never depend on the enable, so a blocked request waits
    assign gated_next = flag_next & enable & VEC_IMPL;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // both vectors held while the clock enable is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag  <= STATUS_RESET;
            gated <= STATUS_RESET;
        end else if (clk_en) begin
            flag  <= flag_next;
            gated <= gated_next;
        end
    end

endmodule

// file: rtl/iie_pkg.sv
// shared constants, types and layouts for the interrupt enable gating block
package iie_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses inside the slave window)
    // ------------------------------------------------------------------
    localparam int unsigned   AW           = 12;
    localparam logic [11:0]   OFS_EN0      = 12'h000;
    localparam logic [11:0]   OFS_EN1      = 12'h004;
    localparam logic [11:0]   OFS_STATUS   = 12'h008;
    localparam logic [11:0]   OFS_MASK     = 12'h00C;

    // ------------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0]   EN0_IMPL     = 16'h0007;
    localparam logic [15:0]   EN1_IMPL     = 16'hFF1F;
    localparam logic [31:0]   VEC_IMPL     = {EN1_IMPL, EN0_IMPL};
    localparam logic [15:0]   EN0_RESET    = 16'h0000;
    localparam logic [15:0]   EN1_RESET    = 16'h0000;
    localparam logic [31:0]   MASK_RESET   = 32'h0000_0000;
    localparam logic [31:0]   STATUS_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // bus constants and timing counts
    // ------------------------------------------------------------------
    localparam logic [2:0]    HSIZE_WORD   = 3'h2;
    localparam logic          HRESP_OKAY   = 1'h0;
    localparam int unsigned   RD_WAIT      = 1;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_EN0    = 3'b000,
        SEL_EN1    = 3'b001,
        SEL_STATUS = 3'b010,
        SEL_MASK   = 3'b011,
        SEL_NONE   = 3'b100
    } iie_sel_t;

    // sources gated by the first enable register
    typedef struct packed {
        logic [12:0] unused;
        logic        out_compare1;
        logic        in_capture1;
        logic        ext_pin0;
    } iie_src0_t;

    // sources gated by the second enable register
    typedef struct packed {
        logic        serial2_tx;
        logic        serial2_rx;
        logic        ext_pin2;
        logic        timer_five;
        logic        timer_four;
        logic        out_compare4;
        logic        out_compare3;
        logic        dma_chan2_done;
        logic [2:0]  unused;
        logic        ext_pin1;
        logic        change_notify;
        logic        analog_cmp1;
        logic        twowire1_master;
        logic        twowire1_slave;
    } iie_src1_t;

    // one bit per source, same layout as status and mask
    typedef struct packed {
        iie_src1_t hi;
        iie_src0_t lo;
    } iie_irq_vec_t;

    // captured address phase
    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
    } iie_aphase_t;

endpackage

// file: rtl/iie_top.sv
// ahb-lite register slave with enable gating of peripheral interrupt requests
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module iie_top
    import iie_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         clk_en,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    input  wire iie_irq_vec_t irq_src,
    output iie_irq_vec_t      irq_to_arb,
    output logic              irq
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // address to register select; anything else is unmapped
    function automatic iie_sel_t reg_sel(input logic [AW-1:0] a);
        iie_sel_t s;
        s = SEL_NONE;
        case (a)
            OFS_EN0:    s = SEL_EN0;
            OFS_EN1:    s = SEL_EN1;
            OFS_STATUS: s = SEL_STATUS;
            OFS_MASK:   s = SEL_MASK;
            default:    s = SEL_NONE;
        endcase
        return s;
    endfunction

    // keep only implemented bits of a value
    function automatic logic [15:0] impl16(
        input logic [15:0] v,
        input logic [15:0] impl
    );
        return v & impl;
    endfunction

    // ------------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------------
    iie_aphase_t  dphase_reg;
    iie_aphase_t  dphase_next;
    logic [15:0]  en0_reg;
    logic [15:0]  en0_next;
    logic [15:0]  en1_reg;
    logic [15:0]  en1_next;
    logic [31:0]  mask_reg;
    logic [31:0]  mask_next;
    logic         hreadyout_reg;
    logic         hreadyout_next;
    logic [31:0]  hrdata_reg;
    logic [31:0]  hrdata_next;
    logic         irq_reg;
    logic         irq_next;

    // ------------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------------
    logic         aphase_take;
    logic         aphase_word;

    // a transfer starts only on a NONSEQ or SEQ with the bus ready
    assign aphase_take = hsel & htrans[1] & hready;
    // sub-word writes are dropped; a read of any size returns the word
    assign aphase_word = (hsize == HSIZE_WORD);

    assign dphase_next.wr   = aphase_take & hwrite & aphase_word;
    assign dphase_next.rd   = aphase_take & ~hwrite;
    assign dphase_next.addr = haddr[AW-1:0];

    // the captured phase only advances when the bus moves on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_reg <= '0;
        end else if (clk_en && hready) begin
            dphase_reg <= dphase_next;
        end
    end

    // ------------------------------------------------------------------
    // data phase decode
    // ------------------------------------------------------------------
    iie_sel_t     dsel;
    logic         wr_commit;
    logic         rd_stall;
    logic         wr_en0;
    logic         wr_en1;
    logic         wr_status;
    logic         wr_mask;

    assign dsel      = reg_sel(dphase_reg.addr);
    // writes complete with no wait state
    assign wr_commit = dphase_reg.wr & hready;
    // reads take one wait state so the read word comes from a flop
    assign rd_stall  = dphase_reg.rd & ~hready;

    assign wr_en0    = wr_commit & (dsel == SEL_EN0);
    assign wr_en1    = wr_commit & (dsel == SEL_EN1);
    assign wr_status = wr_commit & (dsel == SEL_STATUS);
    assign wr_mask   = wr_commit & (dsel == SEL_MASK);

    // ------------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------------

    // unimplemented positions are forced to zero on every write
    assign en0_next = wr_en0 ? impl16(hwdata[15:0], EN0_IMPL) : en0_reg;
    assign en1_next = wr_en1 ? impl16(hwdata[15:0], EN1_IMPL) : en1_reg;

    // software owns these bits; hardware never changes them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en0_reg <= EN0_RESET;
            en1_reg <= EN1_RESET;
        end else if (clk_en) begin
            en0_reg <= en0_next;
            en1_reg <= en1_next;
        end
    end

    // ------------------------------------------------------------------
    // enable vector in source layout
    // ------------------------------------------------------------------
    iie_irq_vec_t enable_vec;

    // first register: bits 2..0 only
    assign enable_vec.lo.unused       = '0;
    assign enable_vec.lo.out_compare1 = en0_reg[2];
    assign enable_vec.lo.in_capture1  = en0_reg[1];
    assign enable_vec.lo.ext_pin0     = en0_reg[0];

    // second register: upper byte
    assign enable_vec.hi.serial2_tx     = en1_reg[15];
    assign enable_vec.hi.serial2_rx     = en1_reg[14];
    assign enable_vec.hi.ext_pin2       = en1_reg[13];
    assign enable_vec.hi.timer_five     = en1_reg[12];
    assign enable_vec.hi.timer_four     = en1_reg[11];
    assign enable_vec.hi.out_compare4   = en1_reg[10];
    assign enable_vec.hi.out_compare3   = en1_reg[9];
    assign enable_vec.hi.dma_chan2_done = en1_reg[8];

    // second register: low byte, with a three bit hole
    assign enable_vec.hi.unused          = '0;
    assign enable_vec.hi.ext_pin1        = en1_reg[4];
    assign enable_vec.hi.change_notify   = en1_reg[3];
    assign enable_vec.hi.analog_cmp1     = en1_reg[2];
    assign enable_vec.hi.twowire1_master = en1_reg[1];
    assign enable_vec.hi.twowire1_slave  = en1_reg[0];

    // ------------------------------------------------------------------
    // status flags and gating
    // ------------------------------------------------------------------
    iie_irq_vec_t flag_clr;
    iie_irq_vec_t flag_vec;

    // write-one-to-clear; the write only reaches the status bits
    assign flag_clr = wr_status ? (hwdata & VEC_IMPL) : '0;

    // flags are kept apart from the enables so that toggling an
    // enable cannot lose or invent a request
    iie_gate u_gate (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_en   (clk_en),
        .src_req  (irq_src),
        .enable   (enable_vec),
        .flag_clr (flag_clr),
        .flag     (flag_vec),
        .gated    (irq_to_arb)
    );

    // ------------------------------------------------------------------
    // interrupt mask and output
    // ------------------------------------------------------------------

    // mask uses the status layout; holes stay zero
    assign mask_next = wr_mask ? (hwdata & VEC_IMPL) : mask_reg;

    // only requests already past their enable can raise the line
    assign irq_next  = |(irq_to_arb & mask_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_reg <= MASK_RESET;
            irq_reg  <= 1'b0;
        end else if (clk_en) begin
            mask_reg <= mask_next;
            irq_reg  <= irq_next;
        end
    end

    // ------------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------------
    logic [31:0]  rd_word;

    // unmapped reads answer zero, reserved bits read zero
    assign rd_word = (dsel == SEL_EN0)    ? {16'h0000, en0_reg} :
                     (dsel == SEL_EN1)    ? {16'h0000, en1_reg} :
                     (dsel == SEL_STATUS) ? flag_vec :
                     (dsel == SEL_MASK)   ? mask_reg :
                                            32'h0000_0000;

    // word captured during the wait state, held until the next read
    assign hrdata_next = rd_stall ? rd_word : hrdata_reg;

    // ready drops for exactly one cycle after a read is taken
    assign hreadyout_next = hready ? ~(aphase_take & ~hwrite) : 1'b1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
        end else if (clk_en) begin
            hrdata_reg    <= hrdata_next;
            hreadyout_reg <= hreadyout_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = HRESP_OKAY; // constant, never an error
    assign irq       = irq_reg;

endmodule

// file: testbench/iie_src_model.sv
// peripheral request source model feeding the gating block
`timescale 1ns/1ps
module iie_src_model
    import iie_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        fire,
    input  wire logic [31:0] pattern,
    output iie_irq_vec_t     irq_src
);
    // one-cycle pulse; lines drop low again so only sticky flags remember it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_src <= '0;
        end else begin
            irq_src <= fire ? iie_irq_vec_t'(pattern) : '0;
        end
    end
endmodule

// file: testbench/iie_top_assertions.sv
// concurrent port checks for the interrupt enable gating slave
`timescale 1ns/1ps
module iie_top_assertions
    import iie_pkg::*;
(
    input wire logic         hclk,
    input wire logic         hresetn,
    input wire logic         clk_en,
    input wire logic         hsel,
    input wire logic [31:0]  haddr,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic [2:0]   hsize,
    input wire logic [31:0]  hwdata,
    input wire logic         hready,
    input wire logic         hreadyout,
    input wire logic         hresp,
    input wire logic [31:0]  hrdata,
    input wire iie_irq_vec_t irq_src,
    input wire iie_irq_vec_t irq_to_arb,
    input wire logic         irq
);
    // ------------------------------------------------------------------
    // helper: taken transfers and the address of the pending read
    // ------------------------------------------------------------------
    wire         rd_take = hsel && htrans[1] && hready && !hwrite && clk_en;
    wire         wr_take = hsel && htrans[1] && hready && hwrite && clk_en;
    logic [11:0] rd_addr_reg;

    // address kept so the read result can be judged when it lands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_addr_reg <= 12'h000;
        end else if (rd_take) begin
            rd_addr_reg <= haddr[11:0];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_resp_okay;
        hresp == HRESP_OKAY;
    endproperty
    property p_impl_only;
        (irq_to_arb & ~VEC_IMPL) == 32'h0000_0000;
    endproperty
    property p_read_wait;
        rd_take |=> !hreadyout ##1 hreadyout;
    endproperty
    property p_write_nowait;
        wr_take |=> hreadyout;
    endproperty
    property p_en1_reserved;
        $rose(hreadyout) && rd_addr_reg == OFS_EN1 |-> hrdata[31:16] == 16'h0000 && hrdata[7:5] == 3'h0;
    endproperty
    property p_en0_reserved;
        $rose(hreadyout) && rd_addr_reg == OFS_EN0 |-> hrdata[31:3] == 29'h0000_0000;
    endproperty
    property p_hrdata_hold;
        $changed(hrdata) |-> $rose(hreadyout);
    endproperty
    property p_irq_cause;
        irq |-> $past(irq_to_arb) != 32'h0000_0000;
    endproperty
    property p_reset_clear;
        $rose(hresetn) |-> irq_to_arb == 32'h0000_0000 && !irq;
    endproperty

    a_resp_okay: assert property (p_resp_okay) else $error("hresp not okay");
    a_impl_only: assert property (p_impl_only) else $error("unimplemented gate bit set");
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
    a_en1_reserved: assert property (p_en1_reserved) else $error("en1 reserved bits set");
    a_en0_reserved: assert property (p_en0_reserved) else $error("en0 upper bits set");
    a_hrdata_hold: assert property (p_hrdata_hold) else $error("hrdata moved outside a read");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without gated request");
    a_reset_clear: assert property (p_reset_clear) else $error("requests not clear at reset");

    c_read: cover property (rd_take ##2 hreadyout);
    c_irq: cover property ($rose(irq));
    c_gated: cover property (irq_to_arb != 32'h0000_0000);
endmodule

bind iie_top iie_top_assertions iie_top_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_src(irq_src),
    .irq_to_arb(irq_to_arb), .irq(irq)
);

// file: testbench/tb.sv
// self-checking bench for the interrupt enable gating slave
`timescale 1ns/1ps
module tb;
    import iie_pkg::*;
    logic         hclk = 1'b0;
    logic         hresetn = 1'b0;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic         src_go = 1'b0;
    logic [31:0]  src_pat = 32'h0;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    iie_irq_vec_t irq_src;
    iie_irq_vec_t irq_to_arb;
    logic         irq;
    int           error_cnt = 0;
    int           checks_done = 0;
    integer       seed = 32'h8B85;
    logic [31:0]  st, en, msk, src, rd;

    always #10 hclk = ~hclk;

    iie_top iie_top_inst (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq_src(irq_src), .irq_to_arb(irq_to_arb), .irq(irq)
    );
    iie_src_model iie_src_model_inst (
        .hclk(hclk), .hresetn(hresetn), .fire(src_go), .pattern(src_pat), .irq_src(irq_src)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run;
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_ready;
        for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        error_cnt++;
        complete_run;
    endtask

    // one single word transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h00000, a};
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask

    // ------------------------------------------------------------------
    // main sequence: walking enable bit, then random enables and sources
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a < 20; a += 4) begin
            ahb(1'b0, a[11:0], 32'h0);
            check("reset_read", 32'h0, rd);
        end
        for (int i = 0; i < 48; i++) begin
            en = (i < 32) ? (32'h1 << i) : $random(seed);
            src = (i < 32) ? 32'hFFFF_FFFF : $random(seed);
            msk = $random(seed);
            ahb(1'b1, OFS_EN0, 32'h0);
            ahb(1'b1, OFS_EN1, 32'h0);
            src_pat <= src;
            src_go <= 1'b1;
            @(posedge hclk);
            src_go <= 1'b0;
            st = src & VEC_IMPL;
            // flag and gate register on the same edge, one after the source; three leaves margin
            repeat (3) @(posedge hclk);
            check("gated_off", 32'h0, irq_to_arb);
            ahb(1'b0, OFS_STATUS, 32'h0);
            check("status", st, rd);
            ahb(1'b1, OFS_EN0, {16'h0000, en[15:0]});
            ahb(1'b1, OFS_EN1, {16'h0000, en[31:16]});
            ahb(1'b1, OFS_MASK, msk);
            repeat (3) @(posedge hclk);
            en = en & VEC_IMPL;
            check("gated_on", st & en, irq_to_arb);
            check("irq", {31'h0, |(st & en & msk)}, {31'h0, irq});
            ahb(1'b0, OFS_EN1, 32'h0);
            check("en1_read", {16'h0000, en[31:16]}, rd);
            ahb(1'b0, OFS_EN0, 32'h0);
            check("en0_read", {16'h0000, en[15:0]}, rd);
            ahb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
            st = 32'h0;
            repeat (3) @(posedge hclk);
            check("cleared", st, irq_to_arb);
        end
        complete_run;
    end
endmodule
